// file: verilog/cbp_map.svh
// register map, field positions and timing constants of the charger protection sequencer
`ifndef CBP_MAP_SVH
`define CBP_MAP_SVH
`define CBP_CLK_HZ 100000000
`define CBP_RST_SHORT_MS 400
`define CBP_RST_LONG_MS 2000
`define CBP_SWITCH_DELAY_US 800
`define CBP_BLANK_CYC 8'h04
`define CBP_UV_QUAL_CYC 16'h0400
`define CBP_DITHER_MAX 8'h3c
`define CBP_LFSR_SEED 16'hace1
`define CBP_ADDR_CTRL 8'h00
`define CBP_ADDR_STAT 8'h04
`define CBP_ADDR_DITH 8'h08
`define CBP_CTRL_SPREAD_EN 0
`define CBP_CTRL_TIMEOUT 1
`define CBP_RESP_OKAY 2'h0
`define CBP_RESP_SLVERR 2'h2
`endif

// file: verilog/cbp_pkg.sv
// types shared by the charger protection sequencer
package cbp_pkg;
  typedef enum logic [1:0] {
    CBP_MODE_DCP = 2'h0,
    CBP_MODE_CDP = 2'h1,
    CBP_MODE_SDP = 2'h2
  } cbp_mode_t;
  typedef enum logic [2:0] {
    CBP_ST_OFF = 3'h0,
    CBP_ST_SOFTSTART = 3'h1,
    CBP_ST_RUN = 3'h2,
    CBP_ST_HICCUP_DIS = 3'h3,
    CBP_ST_HICCUP_RETRY = 3'h4,
    CBP_ST_VBUS_RESET = 3'h5
  } cbp_state_t;
  // analog comparator indications, pin levels and the cycle end marker
  typedef struct packed {
    logic enable_in;
    logic vin_above_rise;
    logic vin_below_fall;
    logic spread_enable_pin;
    logic ext_sync;
    logic hs_overcurrent;
    logic ls_source_over;
    logic ls_sink_over;
    logic fb_below_half;
    logic fb_below_pg;
    logic zero_current;
    logic ss_below_150mv;
    logic ss_fb_above_400mv;
    logic ss_fb_above_700mv;
    logic ss_done;
    logic thermal_shutdown;
    logic dline_ovp;
    logic vcc_por;
    logic cycle_end;
  } cbp_ind_t;
  typedef struct packed {
    logic hs_on;
    logic ls_on;
    logic ss_charge;
    logic ss_discharge_weak;
    logic vbus_discharge_pin;
    logic data_switch_on;
    logic dither_on;
    logic [7:0] dither_step;
  } cbp_out_t;
endpackage

// file: verilog/cbp_sequencer.sv
// control and protection sequencer for the charging-port buck converter
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "cbp_map.svh"

// Behaviour
// R1: no dithering before soft-start done or at zero current
// R2: dithering follows the spread enable pin
// R3: pseudo-random dither, frequency raised only, up to 6%
// R4: external sync forces dithering off
// R5: no switching until supply above lockout rise
// R6: stop below lockout fall, resume above rise; code also stops whenever the rise flag is low
// R7: blanked high-side limit, then high off, low on
// R8: low-side source above limit blocks new cycle
// R9: low-side sink over limit: low off, high on
// R10: undervoltage: high off, low off at zero current
// R11: persistent undervoltage enters hiccup, weak ramp discharge
// R12: ramp below 150mV restarts charging
// R13: retry switches at 400mV, stops at 700mV
// R14: clean retry resumes normal, else repeat
// R15: thermal halt, full soft-start on recovery
// R16: mode change: discharge pin, ramp low, restart
// R17: timeout during reset repeats the reset
// R18: reset after line fault, fault release, power-good drop
// R19: reset time 400ms leaving dedicated, else 2s
// R20: data switch closed in downstream or standard mode
// R21: data switch closes 800us after supply reset
// R22: data switch opens when supply falls to reset
// R23: enable low inhibits switching
// R24: all comparator indications synchronised first
// R25: timers count cycles from clock frequency parameter
module cbp_sequencer #(
  parameter int unsigned CLK_HZ = `CBP_CLK_HZ,
  parameter int unsigned RST_SHORT_CYC = CLK_HZ / 1000 * `CBP_RST_SHORT_MS,
  parameter int unsigned RST_LONG_CYC = CLK_HZ / 1000 * `CBP_RST_LONG_MS,
  parameter int unsigned SWITCH_DELAY_CYC = CLK_HZ / 1000000 * `CBP_SWITCH_DELAY_US
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // analog indications and pins
  input wire cbp_pkg::cbp_ind_t ind,
  input wire logic [1:0] charge_mode_select,
  // power stage and pin controls
  output cbp_pkg::cbp_out_t ctl,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  typedef struct packed {
    cbp_pkg::cbp_ind_t s1;
    cbp_pkg::cbp_ind_t s2;
    logic [1:0] mode_s1;
    logic [1:0] mode_s2;
    logic [1:0] mode_prev;
    logic mode_valid;
    cbp_pkg::cbp_state_t st;
    logic [7:0] blank_cnt;
    logic [15:0] uv_cnt;
    logic [31:0] rst_cnt;
    logic [31:0] rst_len;
    logic [31:0] sw_cnt;
    logic sw_ready;
    logic dline_prev;
    logic fault_prev;
    logic pg_prev;
    logic [15:0] lfsr;
    logic spread_ctrl;
    logic timeout_req;
    logic retry;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    cbp_pkg::cbp_out_t o;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t q, d;

  // mode leaving dedicated port for downstream or standard takes the short time
  function automatic logic [31:0] reset_len(input logic [1:0] from, input logic [1:0] to);
    if (from == cbp_pkg::CBP_MODE_DCP && (to == cbp_pkg::CBP_MODE_CDP || to == cbp_pkg::CBP_MODE_SDP)) begin
      return RST_SHORT_CYC; // R19
    end
    return RST_LONG_CYC; // R19
  endfunction

  function automatic logic data_mode(input logic [1:0] m);
    return m == cbp_pkg::CBP_MODE_CDP || m == cbp_pkg::CBP_MODE_SDP;
  endfunction

  logic can_switch;
  logic fault_now;
  logic uv_expired;

  always_comb begin
    d = q;
    // two-stage synchronisers; only stage two is read
    d.s1 = ind; // R24
    d.s2 = q.s1; // R24
    d.mode_s1 = charge_mode_select;
    d.mode_s2 = q.mode_s1;

    // enable and lockout gate; no latch: stops when the rise flag is low or the fall flag is set
    can_switch = q.s2.enable_in && q.s2.vin_above_rise && !q.s2.thermal_shutdown; // R5 R23 R15
    fault_now = q.s2.thermal_shutdown || q.s2.fb_below_half;
    uv_expired = q.uv_cnt == `CBP_UV_QUAL_CYC;

    d.o.hs_on = 1'b0;
    d.o.ls_on = 1'b0;
    d.o.ss_charge = 1'b0;
    d.o.ss_discharge_weak = 1'b0;
    d.o.vbus_discharge_pin = 1'b0;

    // reset triggers
    d.dline_prev = q.s2.dline_ovp;
    d.fault_prev = fault_now;
    d.pg_prev = q.s2.fb_below_pg;
    d.mode_prev = q.mode_s2;
    d.mode_valid = 1'b1;

    unique case (q.st)
      cbp_pkg::CBP_ST_OFF: begin
        d.blank_cnt = 8'h00;
        d.uv_cnt = 16'h0000;
        if (can_switch && !q.s2.vin_below_fall) begin
          d.st = cbp_pkg::CBP_ST_SOFTSTART; // R5 R6
        end
      end
      cbp_pkg::CBP_ST_SOFTSTART, cbp_pkg::CBP_ST_RUN, cbp_pkg::CBP_ST_HICCUP_RETRY: begin
        d.o.ss_charge = 1'b1; // R12
        if (q.st == cbp_pkg::CBP_ST_HICCUP_RETRY && q.s2.ss_fb_above_700mv && q.s2.fb_below_half) begin
          d.st = cbp_pkg::CBP_ST_HICCUP_DIS; // R13 R14
        end else if (q.st != cbp_pkg::CBP_ST_RUN && q.s2.ss_done && !q.s2.fb_below_half) begin
          d.st = cbp_pkg::CBP_ST_RUN; // R14
        end
        // power stage: default phase toggles high/low at each cycle end marker, one whole period each
        if (q.s2.fb_below_half) begin
          d.o.hs_on = 1'b0; // R10
          d.o.ls_on = q.o.ls_on && !q.s2.zero_current; // R10
          if (q.st != cbp_pkg::CBP_ST_HICCUP_RETRY) begin
            d.uv_cnt = uv_expired ? q.uv_cnt : q.uv_cnt + 16'h0001;
            if (uv_expired) begin
              d.st = cbp_pkg::CBP_ST_HICCUP_DIS; // R11
            end
          end
        end else if (q.s2.ls_sink_over) begin
          d.o.ls_on = 1'b0; // R9
          d.o.hs_on = 1'b1; // R9
        end else if (q.o.hs_on) begin
          d.uv_cnt = 16'h0000;
          d.blank_cnt = (q.blank_cnt == `CBP_BLANK_CYC) ? q.blank_cnt : q.blank_cnt + 8'h01;
          if (q.blank_cnt == `CBP_BLANK_CYC && q.s2.hs_overcurrent) begin
            d.o.hs_on = 1'b0; // R7
            d.o.ls_on = 1'b1; // R7
          end else begin
            d.o.hs_on = !q.s2.cycle_end;
            d.o.ls_on = q.s2.cycle_end;
          end
        end else begin
          d.uv_cnt = 16'h0000;
          d.blank_cnt = 8'h00;
          d.o.ls_on = 1'b1;
          // new cycle only at the clock edge and below the source limit
          if (q.s2.cycle_end && !q.s2.ls_source_over &&
              (q.st == cbp_pkg::CBP_ST_RUN || q.s2.ss_fb_above_400mv)) begin // R8 R13
            d.o.hs_on = 1'b1;
            d.o.ls_on = 1'b0;
          end
        end
      end
      cbp_pkg::CBP_ST_HICCUP_DIS: begin
        d.o.ss_discharge_weak = 1'b1; // R11
        d.uv_cnt = 16'h0000;
        if (q.s2.ss_below_150mv) begin
          d.st = cbp_pkg::CBP_ST_HICCUP_RETRY; // R12
        end
      end
      cbp_pkg::CBP_ST_VBUS_RESET: begin
        d.o.vbus_discharge_pin = 1'b1; // R16
        d.rst_cnt = q.rst_cnt + 32'h1; // R25
        if (q.timeout_req) begin
          d.rst_cnt = 32'h0; // R17
        end else if (q.rst_cnt >= q.rst_len) begin
          d.st = cbp_pkg::CBP_ST_OFF; // R16
        end
      end
      default: begin
        d.st = cbp_pkg::CBP_ST_OFF;
      end
    endcase

    // stop conditions override every switching state
    if (q.st != cbp_pkg::CBP_ST_VBUS_RESET && q.st != cbp_pkg::CBP_ST_HICCUP_DIS &&
        (!can_switch || q.s2.vin_below_fall)) begin
      d.st = cbp_pkg::CBP_ST_OFF; // R6 R15 R23
      d.o.hs_on = 1'b0;
      d.o.ls_on = 1'b0;
      d.o.ss_charge = 1'b0;
    end

    // vbus reset entry: mode change or listed event on re-power
    if (q.mode_valid && (q.mode_s2 != q.mode_prev)) begin
      d.st = cbp_pkg::CBP_ST_VBUS_RESET; // R16
      d.rst_cnt = 32'h0;
      d.rst_len = reset_len(q.mode_prev, q.mode_s2); // R19
    end else if (q.st != cbp_pkg::CBP_ST_VBUS_RESET &&
                 ((q.dline_prev && !q.s2.dline_ovp) || (q.fault_prev && !fault_now) ||
                  (q.st == cbp_pkg::CBP_ST_RUN && !q.pg_prev && q.s2.fb_below_pg))) begin
      d.st = cbp_pkg::CBP_ST_VBUS_RESET; // R18
      d.rst_cnt = 32'h0;
      d.rst_len = RST_SHORT_CYC;
    end
    if (d.st == cbp_pkg::CBP_ST_VBUS_RESET) begin
      d.o.hs_on = 1'b0;
      d.o.ls_on = 1'b0;
      d.o.ss_charge = 1'b0;
    end

    // data switch: delay after supply reset, open when supply falls
    if (!q.s2.vcc_por) begin
      d.sw_cnt = 32'h0;
      d.sw_ready = 1'b0; // R22
    end else if (q.sw_cnt >= SWITCH_DELAY_CYC) begin
      d.sw_ready = 1'b1; // R21
    end else begin
      d.sw_cnt = q.sw_cnt + 32'h1; // R25
    end
    d.o.data_switch_on = q.sw_ready && data_mode(q.mode_s2) && !q.s2.dline_ovp; // R20

    // dither: lfsr only pushes frequency upward, capped near six percent
    d.lfsr = {q.lfsr[14:0], q.lfsr[15] ^ q.lfsr[13] ^ q.lfsr[12] ^ q.lfsr[10]}; // R3
    d.o.dither_on = q.st == cbp_pkg::CBP_ST_RUN && q.s2.ss_done && !q.s2.zero_current &&
                    q.s2.spread_enable_pin && q.spread_ctrl && !q.s2.ext_sync; // R1 R2 R4
    d.o.dither_step = d.o.dither_on ?
                      ((q.lfsr[7:0] > `CBP_DITHER_MAX) ? `CBP_DITHER_MAX : q.lfsr[7:0]) : 8'h00; // R3

    // axi4-lite write: address and data in either order
    d.timeout_req = q.timeout_req && q.st == cbp_pkg::CBP_ST_VBUS_RESET && d.rst_cnt != 32'h0;
    if (s_axi_awvalid && q.awready) begin
      d.aw_got = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_got = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    d.awready = !d.aw_got && !q.bvalid;
    d.wready = !d.w_got && !q.bvalid;
    if (q.aw_got && q.w_got && !q.bvalid) begin
      d.bvalid = 1'b1;
      d.bresp = `CBP_RESP_OKAY;
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.awready = 1'b0;
      d.wready = 1'b0;
      if (q.aw_addr == `CBP_ADDR_CTRL) begin
        if (q.w_strb[0]) begin
          d.spread_ctrl = q.w_data[`CBP_CTRL_SPREAD_EN];
          d.timeout_req = q.w_data[`CBP_CTRL_TIMEOUT] && q.st == cbp_pkg::CBP_ST_VBUS_RESET; // R17
        end
      end else if (q.aw_addr != `CBP_ADDR_STAT && q.aw_addr != `CBP_ADDR_DITH) begin
        d.bresp = `CBP_RESP_SLVERR;
      end
    end else if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
      d.awready = !q.aw_got;
      d.wready = !q.w_got;
    end

    // axi4-lite read
    if (s_axi_arvalid && q.arready) begin
      d.arready = 1'b0;
      d.rvalid = 1'b1;
      d.rresp = `CBP_RESP_OKAY;
      d.rdata = 32'h0;
      unique case (s_axi_araddr)
        `CBP_ADDR_CTRL: d.rdata = {30'h0, q.timeout_req, q.spread_ctrl};
        `CBP_ADDR_STAT: d.rdata = {20'h0, q.sw_ready, q.o.data_switch_on, q.o.vbus_discharge_pin,
                                   q.o.ls_on, q.o.hs_on, q.mode_s2, 2'h0, q.st};
        `CBP_ADDR_DITH: d.rdata = {23'h0, q.o.dither_on, q.o.dither_step};
        default: d.rresp = `CBP_RESP_SLVERR;
      endcase
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
      d.arready = 1'b1;
    end

    if (!aresetn) begin
      d = '0;
      d.st = cbp_pkg::CBP_ST_OFF;
      d.lfsr = `CBP_LFSR_SEED;
      d.rst_len = RST_LONG_CYC;
      d.awready = 1'b1;
      d.wready = 1'b1;
      d.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    q <= d;
  end

  assign ctl = q.o;
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;

endmodule

// file: sim/cbp_sequencer_properties.sv
// concurrent checks on the charger protection sequencer ports
`timescale 1ns/1ps
module cbp_sequencer_properties #(
  parameter int unsigned SWITCH_DELAY_CYC = 20
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // indications and controls
  input wire cbp_pkg::cbp_ind_t ind,
  input wire logic [1:0] charge_mode_select,
  input wire cbp_pkg::cbp_out_t ctl,
  // read channel
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  logic [31:0] por_cnt_q;
  logic [31:0] por_cnt_d;
  // raw supply flag is seen here before the design syncs it, so this count is never behind
  always_comb begin
    por_cnt_d = ind.vcc_por ? por_cnt_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_cnt_q <= 32'h0;
    end else begin
      por_cnt_q <= por_cnt_d;
    end
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence mode_changed_s;
    $changed(charge_mode_select) ##1 $stable(charge_mode_select) [*4];
  endsequence
  sequence vbus_started_s;
    ##[0:6] ctl.vbus_discharge_pin;
  endsequence
  dither_cap_a: assert property (ctl.dither_step <= 8'h3c)
    else $error("dither step above limit");
  sync_dither_off_a: assert property (ind.ext_sync [*5] |-> !ctl.dither_on)
    else $error("dither while synchronised");
  pin_dither_off_a: assert property (!ind.spread_enable_pin [*5] |-> !ctl.dither_on)
    else $error("dither with pin low");
  zero_dither_off_a: assert property (ind.zero_current [*5] |-> !ctl.dither_on)
    else $error("dither at zero current");
  enable_inhibit_a: assert property (!ind.enable_in [*5] |-> !ctl.hs_on)
    else $error("switching with enable low");
  lockout_stop_a: assert property (ind.vin_below_fall [*5] |-> !ctl.hs_on)
    else $error("switching below lockout");
  thermal_halt_a: assert property (ind.thermal_shutdown [*5] |-> !ctl.hs_on && !ctl.ls_on)
    else $error("switching while overheated");
  switch_delay_a: assert property ($rose(ctl.data_switch_on) |-> por_cnt_q >= SWITCH_DELAY_CYC)
    else $error("data switch closed early");
  por_switch_off_a: assert property (!ind.vcc_por [*5] |-> !ctl.data_switch_on)
    else $error("data switch closed below supply reset");
  mode_reset_a: assert property (mode_changed_s |-> vbus_started_s)
    else $error("no vbus reset on mode change");
  vbus_off_a: assert property (ctl.vbus_discharge_pin |-> !ctl.hs_on)
    else $error("high side on during vbus reset");
  read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");
endmodule
bind cbp_sequencer cbp_sequencer_properties #(.SWITCH_DELAY_CYC(SWITCH_DELAY_CYC)) cbp_sequencer_properties_inst (
  .aclk(aclk), .aresetn(aresetn), .ind(ind), .charge_mode_select(charge_mode_select), .ctl(ctl),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid)
);

// file: sim/cbp_port_partner.sv
// far side: power stage period marker and the attached portable device load
`timescale 1ns/1ps
module cbp_port_partner (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // converter controls and device presence
  input wire cbp_pkg::cbp_out_t ctl,
  input wire logic attached,
  // indications back to the sequencer
  output logic cycle_end,
  output logic zero_current
);
  logic [2:0] osc_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_q <= 3'h0;
    end else begin
      osc_q <= osc_q + 3'h1;
    end
  end
  assign cycle_end = (osc_q == 3'h7);
  // no current flows while vbus is discharged or nothing draws from it
  assign zero_current = !attached || ctl.vbus_discharge_pin;
endmodule

// file: sim/tb.sv
// self-checking bench for the charger protection sequencer
`timescale 1ns/1ps
`include "cbp_map.svh"
module tb;
  localparam int SHORT = 50;
  localparam int LONG = 200;
  localparam int SDLY = 20;
  logic aclk, aresetn, attached, cyc_end, zc;
  logic [1:0] mode, bresp, rresp;
  cbp_pkg::cbp_ind_t pins;
  cbp_pkg::cbp_ind_t ind;
  cbp_pkg::cbp_out_t ctl;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  int checked, n_mismatch, vb_cnt, vb_len;
  cbp_sequencer #(.RST_SHORT_CYC(SHORT), .RST_LONG_CYC(LONG), .SWITCH_DELAY_CYC(SDLY)) cbp_sequencer_inst (
    .aclk(aclk), .aresetn(aresetn), .ind(ind), .charge_mode_select(mode), .ctl(ctl),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );
  cbp_port_partner cbp_port_partner_inst (
    .aclk(aclk), .aresetn(aresetn), .ctl(ctl), .attached(attached), .cycle_end(cyc_end), .zero_current(zc)
  );
  always_comb begin
    ind = pins;
    ind.cycle_end = cyc_end;
    ind.zero_current = zc;
  end
  // length of the last vbus discharge pulse, latched at its end
  always @(posedge aclk) begin
    if (ctl.vbus_discharge_pin) begin
      vb_cnt <= vb_cnt + 1;
    end else if (vb_cnt != 0) begin
      vb_len <= vb_cnt;
      vb_cnt <= 0;
    end
  end
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        got = 1'b1;
        bready <= 1'b0;
        chk(bresp === exp, "write response");
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        got = 1'b1;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
  endtask
  task automatic wait_st(input logic [2:0] s, input int n);
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < n; i++) begin
      rd(`CBP_ADDR_STAT, d, r);
      if (d[2:0] === s) break;
    end
    chk(d[2:0] === s, "state not reached");
  endtask
  task automatic vb_pulse(input int lo, input int hi);
    int i;
    for (i = 0; i < 20 && ctl.vbus_discharge_pin !== 1'b1; i++) @(posedge aclk);
    for (i = 0; i < hi + 20 && ctl.vbus_discharge_pin !== 1'b0; i++) @(posedge aclk);
    repeat (2) @(posedge aclk);
    chk(vb_len >= lo && vb_len <= hi, "vbus reset length");
  endtask
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rd(`CBP_ADDR_CTRL, d, r);
    chk(d === 32'h0 && r === `CBP_RESP_OKAY, "control reset value");
    wr(`CBP_ADDR_CTRL, 32'h1, `CBP_RESP_OKAY);
    rd(`CBP_ADDR_CTRL, d, r);
    chk(d[0] === 1'b1, "spread gate readback");
    wr(8'h40, 32'h1, `CBP_RESP_SLVERR);
    rd(8'h40, d, r);
    chk(d === 32'h0 && r === `CBP_RESP_SLVERR, "unmapped read");
    $display("test regs done");
  endtask
  task automatic t_start;
    @(posedge aclk);
    pins.enable_in <= 1'b1;
    repeat (20) @(posedge aclk);
    chk(ctl.hs_on === 1'b0, "switching before lockout release");
    pins.vin_above_rise <= 1'b1;
    wait_st(3'h1, 20);
    pins.ss_done <= 1'b1;
    wait_st(3'h2, 20);
    @(posedge aclk);
    pins.enable_in <= 1'b0;
    repeat (8) @(posedge aclk);
    chk(ctl.hs_on === 1'b0, "switching with enable low");
    pins.enable_in <= 1'b1;
    wait_st(3'h2, 30);
    $display("test start done");
  endtask
  task automatic t_dither;
    logic [7:0] lo, hi;
    lo = 8'hff;
    hi = 8'h00;
    @(posedge aclk);
    attached <= 1'b1;
    pins.spread_enable_pin <= 1'b1;
    repeat (12) @(posedge aclk);
    chk(ctl.dither_on === 1'b1, "dither on");
    repeat (300) begin
      @(posedge aclk);
      if (ctl.dither_step < lo) lo = ctl.dither_step;
      if (ctl.dither_step > hi) hi = ctl.dither_step;
    end
    chk(hi <= 8'h3c && hi !== lo, "dither range");
    pins.ext_sync <= 1'b1;
    repeat (8) @(posedge aclk);
    chk(ctl.dither_on === 1'b0, "dither with external clock");
    pins.ext_sync <= 1'b0;
    attached <= 1'b0;
    repeat (8) @(posedge aclk);
    chk(ctl.dither_on === 1'b0, "dither at zero current");
    attached <= 1'b1;
    pins.spread_enable_pin <= 1'b0;
    repeat (8) @(posedge aclk);
    chk(ctl.dither_on === 1'b0, "dither with pin low");
    $display("test dither done");
  endtask
  task automatic t_faults;
    @(posedge aclk);
    pins.vin_above_rise <= 1'b0;
    pins.vin_below_fall <= 1'b1;
    repeat (8) @(posedge aclk);
    chk(ctl.hs_on === 1'b0, "switching below lockout");
    pins.vin_below_fall <= 1'b0;
    pins.vin_above_rise <= 1'b1;
    wait_st(3'h2, 30);
    @(posedge aclk);
    pins.thermal_shutdown <= 1'b1;
    pins.ss_done <= 1'b0;
    repeat (8) @(posedge aclk);
    chk(ctl.hs_on === 1'b0 && ctl.ls_on === 1'b0, "thermal halt");
    pins.thermal_shutdown <= 1'b0;
    wait_st(3'h1, 40);
    pins.ss_done <= 1'b1;
    wait_st(3'h2, 20);
    $display("test faults done");
  endtask
  task automatic t_limits;
    int n;
    @(posedge aclk);
    pins.ls_sink_over <= 1'b1;
    repeat (6) @(posedge aclk);
    chk(ctl.hs_on === 1'b1 && ctl.ls_on === 1'b0, "sink limit response");
    pins.ls_sink_over <= 1'b0;
    pins.ls_source_over <= 1'b1;
    repeat (12) @(posedge aclk);
    n = 0;
    repeat (24) begin
      @(posedge aclk);
      if (ctl.hs_on !== 1'b0) n++;
    end
    chk(n == 0, "cycle started above source limit");
    pins.ls_source_over <= 1'b0;
    pins.hs_overcurrent <= 1'b1;
    for (n = 0; n < 30 && ctl.hs_on !== 1'b1; n++) @(posedge aclk);
    for (n = 0; n < 20 && ctl.hs_on === 1'b1; n++) @(posedge aclk);
    // blanking keeps the high side on a few cycles before the limit acts
    chk(n >= 4 && n <= 6, "high side not cut after blanking");
    pins.hs_overcurrent <= 1'b0;
    wait_st(3'h2, 10);
    $display("test limits done");
  endtask
  task automatic t_hiccup;
    @(posedge aclk);
    pins.fb_below_half <= 1'b1;
    pins.ss_done <= 1'b0;
    repeat (8) @(posedge aclk);
    chk(ctl.hs_on === 1'b0, "high side on at undervoltage");
    wait_st(3'h3, 500);
    chk(ctl.ss_discharge_weak === 1'b1, "hiccup discharge");
    pins.ss_below_150mv <= 1'b1;
    wait_st(3'h4, 20);
    chk(ctl.ss_charge === 1'b1, "retry recharge");
    pins.ss_below_150mv <= 1'b0;
    pins.ss_fb_above_400mv <= 1'b1;
    pins.ss_fb_above_700mv <= 1'b1;
    wait_st(3'h3, 20);
    pins.ss_fb_above_400mv <= 1'b0;
    pins.ss_fb_above_700mv <= 1'b0;
    pins.ss_below_150mv <= 1'b1;
    wait_st(3'h4, 20);
    pins.ss_below_150mv <= 1'b0;
    pins.fb_below_half <= 1'b0;
    pins.ss_done <= 1'b1;
    wait_st(3'h2, 30);
    $display("test hiccup done");
  endtask
  task automatic t_mode;
    logic [1:0] seq [6] = '{2'h1, 2'h0, 2'h2, 2'h1, 2'h2, 2'h0};
    logic [1:0] prev;
    prev = 2'h0;
    foreach (seq[k]) begin
      @(posedge aclk);
      mode <= seq[k];
      vb_len = 0;
      if (prev == 2'h0) vb_pulse(SHORT - 1, SHORT + 2);
      else vb_pulse(LONG - 1, LONG + 2);
      wait_st(3'h2, 30);
      chk(seq[k] == 2'h0 || ctl.data_switch_on === 1'b1, "data switch open in host mode");
      prev = seq[k];
    end
    @(posedge aclk);
    mode <= 2'h1;
    vb_len = 0;
    repeat (10) @(posedge aclk);
    wr(`CBP_ADDR_CTRL, 32'h2, `CBP_RESP_OKAY);
    vb_pulse(SHORT + 8, SHORT + 24);
    wait_st(3'h2, 30);
    pins.fb_below_pg <= 1'b1;
    repeat (4) @(posedge aclk);
    pins.fb_below_pg <= 1'b0;
    vb_len = 0;
    vb_pulse(SHORT - 1, SHORT + 4);
    wait_st(3'h2, 30);
    $display("test mode done");
  endtask
  task automatic t_switch;
    int n;
    @(posedge aclk);
    pins.vcc_por <= 1'b0;
    repeat (8) @(posedge aclk);
    chk(ctl.data_switch_on === 1'b0, "switch closed below supply reset");
    pins.vcc_por <= 1'b1;
    for (n = 0; n < 60 && ctl.data_switch_on !== 1'b1; n++) @(posedge aclk);
    chk(n >= SDLY && n <= SDLY + 6, "switch close delay");
    $display("test switch done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    repeat (40000) @(posedge aclk);
    n_mismatch++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    final_report;
  end
  initial begin
    {aresetn, attached, mode, awaddr, araddr, wdata, wstrb, awvalid, wvalid, bready, arvalid, rready} = '0;
    pins = '0;
    pins.vcc_por = 1'b1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_start;
    t_dither;
    t_faults;
    t_limits;
    t_hiccup;
    t_mode;
    t_switch;
    final_report;
  end
endmodule
